/* File: crc16_link_pkg.sv */
package crc16_link_pkg;
  // Accumulator width and fixed values
  localparam int CRC_W = 16;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SHIFT_MASK = 16'hFFFE;
  localparam logic [15:0] CRC_RESIDUE = 16'h1D0F;
  localparam logic [15:0] CRC_ZERO = 16'h0000;
  // Bits per byte and per check value
  localparam int BYTE_BITS = 8;
  localparam int CHECK_BITS = 16;
  // Counter reset values
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // Check mode encodings
  localparam logic MODE_INVERT = 1'b0;
  localparam logic MODE_RESIDUE = 1'b1;
  // Clock and bit timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_PERIOD_NS = 25000;
  localparam int BIT_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One serial step of the accumulator, shared by both link ends
  function automatic logic [15:0] crc_step(input logic [15:0] acc, input logic bit_in);
    logic fb;
    logic [15:0] nxt;
    fb = bit_in ^ acc[15];
    nxt = {acc[14:0], 1'b0} & CRC_SHIFT_MASK;
    if (fb) begin
      nxt = nxt ^ CRC_POLY;
    end
    return nxt;
  endfunction
endpackage

/* File: crc16_link_if.sv */
interface crc16_link_if;
  // Start of packet, presets the far accumulator
  logic sof;
  // Packet window, high from the start pulse to last check bit
  logic frame;
  // One-cycle strobe per transferred bit
  logic bit_stb;
  // Bit value, valid with the strobe
  logic bit_val;
  // High while the strobed bit belongs to the check value
  logic chk_phase;

  // Sending end
  modport interrogator(output sof, output frame, output bit_stb, output bit_val, output chk_phase);
  // Receiving end
  modport tag(input sof, input frame, input bit_stb, input bit_val, input chk_phase);
endinterface

/* File: crc16_interrogator_end.sv */
// Functional notes
// RULE1 - Preset accumulator to all ones first
// RULE2 - Feedback bit XOR top, poly 1021
// RULE3 - Byte equals eight single bit steps
// RULE4 - Fields enter most significant bit first
// RULE5 - Preamble and delimiter never accumulated
// RULE6 - Interrogator sends complemented CRC, MSB first
// RULE7 - Inverting mode: invert check bits, expect zero
// RULE8 - Plain mode: expect residue 1D0F
// RULE9 - Sixteen bit shift register with taps
// RULE10 - Same CRC for both directions
// RULE11 - Failed check aborts, no response, ready
// RULE12 - Preset, bit strobe, mode, fail flag
module crc16_interrogator_end #(
  parameter int BIT_DIV = crc16_link_pkg::BIT_CYCLES
) (
  input wire logic I_CLK, // System clock
  input wire logic I_RESETN, // Async reset, active low
  crc16_link_if.interrogator LINK, // Serial link to the tag
  input wire logic I_BYTE_VALID, // Byte offered
  input wire logic [7:0] I_BYTE, // Byte of protected fields
  input wire logic I_BYTE_LAST, // Last byte of the packet
  output logic O_BYTE_READY, // Byte taken when valid
  output logic O_BUSY, // Packet in progress
  output logic [15:0] O_CRC // Check value last sent
);
  import crc16_link_pkg::*;

  // Divider range check
  if (BIT_DIV < 1 || BIT_DIV > 65535) begin : g_bad_div
    $error("BIT_DIV out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DATA, S_CHECK} tx_state_t;

  localparam logic [15:0] DIV_LAST = 16'(BIT_DIV - 1);
  localparam logic [4:0] BYTE_LAST_CNT = 5'(BYTE_BITS - 1);
  localparam logic [4:0] CHECK_LAST_CNT = 5'(CHECK_BITS - 1);

  tx_state_t state_q, state_d; // Sequencer
  logic [7:0] sh_q, sh_d; // Byte shifter
  logic last_q, last_d; // Current byte ends packet
  logic [4:0] cnt_q, cnt_d; // Bit counter
  logic [15:0] div_q, div_d; // Bit rate divider
  logic [15:0] crc_accumulator_q, crc_accumulator_d; // Running CRC
  logic [15:0] chk_q, chk_d; // Check value shifter
  logic [15:0] crc_out_q, crc_out_d; // Last check value
  logic sof_q, sof_d; // Link start pulse
  logic frame_q, frame_d; // Link window
  logic stb_q, stb_d; // Link bit strobe
  logic val_q, val_d; // Link bit value
  logic cph_q, cph_d; // Link check phase
  logic tick; // Bit time enable
  logic [15:0] crc_nxt; // Accumulator after this bit

  // Bit enable from the divider
  assign tick = (state_q == S_DATA || state_q == S_CHECK) && (div_q == DIV_LAST);
  // RULE9 - serial shift step
  assign crc_nxt = crc_step(crc_accumulator_q, sh_q[7]);

  // Next state and datapath
  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    last_d = last_q;
    cnt_d = cnt_q;
    div_d = DIV_RESET;
    crc_accumulator_d = crc_accumulator_q;
    chk_d = chk_q;
    crc_out_d = crc_out_q;
    sof_d = 1'b0;
    frame_d = frame_q;
    stb_d = 1'b0;
    val_d = val_q;
    cph_d = cph_q;
    if (state_q == S_DATA || state_q == S_CHECK) begin
      div_d = tick ? DIV_RESET : div_q + 16'h0001;
    end
    case (state_q)
      S_IDLE: begin
        // Window closes one cycle after the last strobe, unless I_BYTE_VALID starts a new packet here
        frame_d = 1'b0;
        cph_d = 1'b0;
        if (I_BYTE_VALID) begin
          sh_d = I_BYTE;
          last_d = I_BYTE_LAST;
          cnt_d = CNT_RESET;
          // RULE1 - preset before packet
          crc_accumulator_d = CRC_PRESET;
          // RULE5 - only protected fields framed
          sof_d = 1'b1;
          frame_d = 1'b1;
          state_d = S_DATA;
        end
      end
      S_WAIT: begin
        // Next byte, no extra state kept
        if (I_BYTE_VALID) begin
          sh_d = I_BYTE;
          last_d = I_BYTE_LAST;
          cnt_d = CNT_RESET;
          state_d = S_DATA;
        end
      end
      S_DATA: begin
        if (tick) begin
          // RULE4 - MSB first on link
          stb_d = 1'b1;
          val_d = sh_q[7];
          // RULE2 - feedback and polynomial
          crc_accumulator_d = crc_nxt;
          sh_d = {sh_q[6:0], 1'b0};
          cnt_d = cnt_q + 5'h01;
          // RULE3 - eight steps per byte
          if (cnt_q == BYTE_LAST_CNT) begin
            cnt_d = CNT_RESET;
            if (last_q) begin
              // RULE6 - complement sent as check
              chk_d = ~crc_nxt;
              crc_out_d = ~crc_nxt;
              state_d = S_CHECK;
            end else begin
              state_d = S_WAIT;
            end
          end
        end
      end
      S_CHECK: begin
        if (tick) begin
          // RULE6 - check value MSB first
          stb_d = 1'b1;
          val_d = chk_q[15];
          cph_d = 1'b1;
          chk_d = {chk_q[14:0], 1'b0};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == CHECK_LAST_CNT) begin
            cnt_d = CNT_RESET;
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= S_IDLE;
      sh_q <= 8'h00;
      last_q <= 1'b0;
      cnt_q <= CNT_RESET;
      div_q <= DIV_RESET;
      crc_accumulator_q <= CRC_PRESET;
      chk_q <= CRC_ZERO;
      crc_out_q <= CRC_ZERO;
      sof_q <= 1'b0;
      frame_q <= 1'b0;
      stb_q <= 1'b0;
      val_q <= 1'b0;
      cph_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      last_q <= last_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      crc_accumulator_q <= crc_accumulator_d;
      chk_q <= chk_d;
      crc_out_q <= crc_out_d;
      sof_q <= sof_d;
      frame_q <= frame_d;
      stb_q <= stb_d;
      val_q <= val_d;
      cph_q <= cph_d;
    end
  end

  // Outputs
  assign O_BYTE_READY = (state_q == S_IDLE) || (state_q == S_WAIT);
  assign O_BUSY = frame_q;
  assign O_CRC = crc_out_q;
  assign LINK.sof = sof_q;
  assign LINK.frame = frame_q;
  assign LINK.bit_stb = stb_q;
  assign LINK.bit_val = val_q;
  assign LINK.chk_phase = cph_q;
endmodule

/* File: crc16_tag_end.sv */
module crc16_tag_end (
  input wire logic I_CLK, // System clock
  input wire logic I_RESETN, // Async reset, active low
  crc16_link_if.tag LINK, // Serial link from interrogator
  input wire logic I_MODE_ALT, // 1 = residue check, 0 = inverting
  output logic [7:0] O_BYTE, // Received protected byte
  output logic O_BYTE_VALID, // Byte strobe
  output logic O_CHECK_DONE, // Check finished strobe
  output logic O_CHECK_FAIL, // Last check failed
  output logic O_ACCEPT, // Packet accepted strobe
  output logic O_ABORT, // Command aborted strobe
  output logic O_READY, // Tag in ready state
  output logic O_RESP_ENABLE, // Response allowed
  output logic [15:0] O_ACC // Accumulator contents
);
  import crc16_link_pkg::*;

  typedef enum logic {T_READY, T_RECV} rx_state_t;

  localparam logic [4:0] BYTE_LAST_CNT = 5'(BYTE_BITS - 1);
  localparam logic [4:0] CHECK_LAST_CNT = 5'(CHECK_BITS - 1);

  rx_state_t state_q, state_d; // Receive sequencer
  logic mode_q, mode_d; // Mode latched at packet start
  logic [15:0] crc_accumulator_q, crc_accumulator_d; // Running CRC
  logic [7:0] sh_q, sh_d; // Byte assembly
  logic [4:0] bcnt_q, bcnt_d; // Bits in byte
  logic [4:0] ccnt_q, ccnt_d; // Check bits taken
  logic [7:0] byte_q, byte_d; // Byte out
  logic bval_q, bval_d; // Byte strobe
  logic done_q, done_d; // Check done strobe
  logic fail_q, fail_d; // Fail flag
  logic acc_q, acc_d; // Accept strobe
  logic abort_q, abort_d; // Abort strobe
  logic resp_q, resp_d; // Response enable
  logic chk_bit; // Check bit as accumulated
  logic [15:0] step_data; // Accumulator after protected bit
  logic [15:0] step_chk; // Accumulator after check bit
  logic pass; // Final value matches

  // RULE7 - invert check bits in inverting mode
  assign chk_bit = (mode_q == MODE_RESIDUE) ? LINK.bit_val : ~LINK.bit_val;
  // RULE9 - serial shift register step
  // RULE10 - shared step function
  assign step_data = crc_step(crc_accumulator_q, LINK.bit_val);
  assign step_chk = crc_step(crc_accumulator_q, chk_bit);
  // RULE8 - residue compare in plain mode
  assign pass = (mode_q == MODE_RESIDUE) ? (step_chk == CRC_RESIDUE) : (step_chk == CRC_ZERO);

  // Next state and datapath
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    crc_accumulator_d = crc_accumulator_q;
    sh_d = sh_q;
    bcnt_d = bcnt_q;
    ccnt_d = ccnt_q;
    byte_d = byte_q;
    bval_d = 1'b0;
    done_d = 1'b0;
    fail_d = fail_q;
    acc_d = 1'b0;
    abort_d = 1'b0;
    resp_d = resp_q;
    case (state_q)
      T_READY: begin
        if (LINK.sof) begin
          // RULE1 - synchronous preset
          crc_accumulator_d = CRC_PRESET;
          // RULE12 - mode sampled at preset
          mode_d = I_MODE_ALT;
          fail_d = 1'b0;
          resp_d = 1'b0;
          bcnt_d = CNT_RESET;
          ccnt_d = CNT_RESET;
          state_d = T_RECV;
        end
      end
      T_RECV: begin
        if (LINK.sof) begin
          // Restart on a new packet
          crc_accumulator_d = CRC_PRESET;
          mode_d = I_MODE_ALT;
          bcnt_d = CNT_RESET;
          ccnt_d = CNT_RESET;
        end else if (!LINK.frame) begin
          // RULE11 - truncated packet aborted
          done_d = 1'b1;
          fail_d = 1'b1;
          abort_d = 1'b1;
          state_d = T_READY;
        end else if (LINK.bit_stb && !LINK.chk_phase) begin
          // RULE5 - only framed protected bits
          // RULE2 - one step per strobe
          crc_accumulator_d = step_data;
          // RULE4 - MSB first assembly
          sh_d = {sh_q[6:0], LINK.bit_val};
          bcnt_d = bcnt_q + 5'h01;
          // RULE3 - byte after eight steps
          if (bcnt_q == BYTE_LAST_CNT) begin
            bcnt_d = CNT_RESET;
            byte_d = {sh_q[6:0], LINK.bit_val};
            bval_d = 1'b1;
          end
        end else if (LINK.bit_stb) begin
          // RULE6 - check value follows fields
          crc_accumulator_d = step_chk;
          ccnt_d = ccnt_q + 5'h01;
          if (ccnt_q == CHECK_LAST_CNT) begin
            // RULE12 - verdict after sixteenth bit
            done_d = 1'b1;
            fail_d = ~pass;
            acc_d = pass;
            resp_d = pass;
            // RULE11 - fail aborts, back to ready
            abort_d = ~pass;
            state_d = T_READY;
          end
        end
      end
      default: begin
        state_d = T_READY;
      end
    endcase
  end

  // State registers
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= T_READY;
      mode_q <= MODE_INVERT;
      crc_accumulator_q <= CRC_PRESET;
      sh_q <= 8'h00;
      bcnt_q <= CNT_RESET;
      ccnt_q <= CNT_RESET;
      byte_q <= 8'h00;
      bval_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      acc_q <= 1'b0;
      abort_q <= 1'b0;
      resp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      crc_accumulator_q <= crc_accumulator_d;
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      ccnt_q <= ccnt_d;
      byte_q <= byte_d;
      bval_q <= bval_d;
      done_q <= done_d;
      fail_q <= fail_d;
      acc_q <= acc_d;
      abort_q <= abort_d;
      resp_q <= resp_d;
    end
  end

  // Outputs
  assign O_BYTE = byte_q;
  assign O_BYTE_VALID = bval_q;
  assign O_CHECK_DONE = done_q;
  assign O_CHECK_FAIL = fail_q;
  assign O_ACCEPT = acc_q;
  assign O_ABORT = abort_q;
  assign O_READY = (state_q == T_READY);
  assign O_RESP_ENABLE = resp_q;
  assign O_ACC = crc_accumulator_q;
endmodule

/* File: crc16_link_checker.sv */
module crc16_link_checker (
  input wire logic I_CLK, // System clock
  input wire logic I_RESETN, // Async reset, active low
  input wire logic sof, // Start of packet
  input wire logic frame, // Packet window
  input wire logic bit_stb, // Bit strobe
  input wire logic bit_val, // Bit value
  input wire logic chk_phase // Check bits on the wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] acc_q, acc_d; // Accumulator over data bits only
  logic [2:0] bit_q, bit_d; // Data bits modulo eight
  logic any_q, any_d; // Some data bit seen
  logic [4:0] cnt_q, cnt_d; // Check bits seen, saturates at 16

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  // Next values of the wire-side model
  always_comb begin
    acc_d = acc_q;
    bit_d = bit_q;
    any_d = any_q;
    cnt_d = cnt_q;
    if (sof) begin // Preset at packet start
      acc_d = 16'hFFFF;
      bit_d = 3'h0;
      any_d = 1'b0;
      cnt_d = 5'h00;
    end else if (bit_stb && !chk_phase) begin // Data bit
      acc_d = {acc_q[14:0], 1'b0} ^ ((acc_q[15] ^ bit_val) ? 16'h1021 : 16'h0000);
      bit_d = bit_q + 3'h1;
      any_d = 1'b1;
    end else if (bit_stb && cnt_q != 5'h10) begin // Check bit
      cnt_d = cnt_q + 5'h01;
    end
  end

  // Register the model
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      acc_q <= 16'hFFFF;
      bit_q <= 3'h0;
      any_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      acc_q <= acc_d;
      bit_q <= bit_d;
      any_q <= any_d;
      cnt_q <= cnt_d;
    end
  end

  // First and last check strobes
  sequence first_chk;
    bit_stb && chk_phase && cnt_q == 5'h00;
  endsequence
  sequence last_chk;
    bit_stb && chk_phase && cnt_q == 5'h0F;
  endsequence

  chk_sof_single: assert property (sof |=> !sof)
    else $error("start pulse longer than one cycle");
  chk_sof_opens: assert property (sof |-> frame ##1 (frame && !chk_phase))
    else $error("start pulse without open window");
  chk_stb_framed: assert property (bit_stb |-> frame && !sof)
    else $error("bit strobe outside the packet");
  chk_phase_framed: assert property (chk_phase |-> frame)
    else $error("check phase outside the window");
  chk_byte_whole: assert property (first_chk |-> any_q && bit_q == 3'h0)
    else $error("check value after a partial byte");
  chk_check_value: assert property ((bit_stb && chk_phase && cnt_q < 5'h10) |->
    bit_val == ~acc_q[4'hF - cnt_q[3:0]])
    else $error("check bit is not the complemented value");
  chk_frame_close: assert property (last_chk |-> ##[1:2] !frame)
    else $error("window not closed after sixteen check bits");
  chk_no_extra: assert property ((frame && cnt_q == 5'h10) |-> !bit_stb)
    else $error("more than sixteen check bits");
endmodule

/* File: testbench.sv */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import crc16_link_pkg::*;
  logic clk, rst_n, bv, bl, m1, m2, d1, d2; // Drives and done flags
  logic [7:0] b, o_byte; // Byte in and out
  logic o_rdy, o_busy, o_bv, o_done, t_fail, t_ok, t_ab, t_ready, t_resp; // First pair
  logic e_done, e_fail, e_ok, e_ab, e_ready, e_resp; // Second tag
  logic [15:0] o_crc, t_acc; // Check values
  logic [20:0] snap1, snap2; // Verdict snapshots
  logic [7:0] rxq[$]; // Bytes seen at the tag
  int checked, n_mismatch, cycles;

  crc16_link_if link();
  crc16_link_if lk();
  crc16_interrogator_end #(.BIT_DIV(3)) crc16_interrogator_end_inst (.I_CLK(clk), .I_RESETN(rst_n),
    .LINK(link), .I_BYTE_VALID(bv), .I_BYTE(b), .I_BYTE_LAST(bl), .O_BYTE_READY(o_rdy),
    .O_BUSY(o_busy), .O_CRC(o_crc));
  crc16_tag_end crc16_tag_end_inst (.I_CLK(clk), .I_RESETN(rst_n), .LINK(link), .I_MODE_ALT(m1),
    .O_BYTE(o_byte), .O_BYTE_VALID(o_bv), .O_CHECK_DONE(o_done), .O_CHECK_FAIL(t_fail),
    .O_ACCEPT(t_ok), .O_ABORT(t_ab), .O_READY(t_ready), .O_RESP_ENABLE(t_resp), .O_ACC(t_acc));
  // Second tag fed by a bench driver that can break the link rules
  crc16_tag_end crc16_tag_end_inst_b (.I_CLK(clk), .I_RESETN(rst_n), .LINK(lk), .I_MODE_ALT(m2),
    .O_BYTE(), .O_BYTE_VALID(), .O_CHECK_DONE(e_done), .O_CHECK_FAIL(e_fail), .O_ACCEPT(e_ok),
    .O_ABORT(e_ab), .O_READY(e_ready), .O_RESP_ENABLE(e_resp), .O_ACC());
  crc16_link_checker crc16_link_checker_inst (.I_CLK(clk), .I_RESETN(rst_n), .sof(link.sof),
    .frame(link.frame), .bit_stb(link.bit_stb), .bit_val(link.bit_val), .chk_phase(link.chk_phase));

  // Clock
  always #10 clk = ~clk;

  // Collect bytes and verdicts where outputs are settled
  always @(negedge clk) begin
    if (o_bv === 1'b1) rxq.push_back(o_byte);
    if (o_done === 1'b1) begin
      d1 = 1'b1;
      snap1 = {t_ok, t_ab, t_fail, t_resp, t_ready, t_acc};
    end
    if (e_done === 1'b1) begin
      d2 = 1'b1;
      snap2 = {e_ok, e_ab, e_fail, e_resp, e_ready, 16'h0000};
    end
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Own serial step of the accumulator
  function automatic logic [15:0] fstep(input logic [15:0] a, input logic d);
    return {a[14:0], 1'b0} ^ ((a[15] ^ d) ? 16'h1021 : 16'h0000);
  endfunction

  // Send n bytes, MSB byte of data first, through the interrogator
  task automatic send_pkt(input logic [31:0] data, input int n, input logic mode);
    logic [15:0] e;
    int k;
    e = 16'hFFFF;
    m1 = mode;
    d1 = 1'b0;
    rxq.delete();
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (o_rdy !== 1'b1 && k < 5000) begin @(negedge clk); k++; end
      bv = 1'b1;
      b = data[31 - 8 * i -: 8];
      bl = (i == n - 1);
      for (int j = 7; j >= 0; j--) e = fstep(e, b[j]);
      @(negedge clk);
      bv = 1'b0;
      if (i == 0) `CHK(o_busy, 1'b1)
    end
    k = 0;
    while (!d1 && k < 5000) begin @(negedge clk); k++; end
    `CHK(d1, 1'b1)
    `CHK(o_busy, 1'b0)
    `CHK(o_crc, ~e)
    `CHK(snap1, {5'b10011, mode ? CRC_RESIDUE : CRC_ZERO})
    `CHK(rxq.size(), n)
    for (int i = 0; i < n; i++) `CHK(rxq[i], data[31 - 8 * i -: 8])
  endtask

  // Drive the second link directly, strobes back to back, nc check bits
  task automatic raw(input logic [7:0] d, input logic [15:0] flip, input int nc, input logic mode,
    input logic [4:0] exp_f);
    logic [15:0] e;
    logic [23:0] s;
    int k;
    e = 16'hFFFF;
    for (int j = 7; j >= 0; j--) e = fstep(e, d[j]);
    s = {d, ~e ^ flip};
    m2 = mode;
    d2 = 1'b0;
    lk.sof = 1'b1;
    lk.frame = 1'b1;
    @(negedge clk);
    lk.sof = 1'b0;
    for (int i = 23; i >= 16 - nc; i--) begin
      lk.bit_stb = 1'b1;
      lk.bit_val = s[i];
      lk.chk_phase = (i < 16);
      @(negedge clk);
    end
    lk.bit_stb = 1'b0;
    lk.frame = 1'b0;
    lk.chk_phase = 1'b0;
    lk.bit_val = ~lk.bit_val;
    // Let the window stay closed for a cycle before any next packet
    @(negedge clk);
    k = 0;
    while (!d2 && k < 100) begin @(negedge clk); k++; end
    `CHK(d2, 1'b1)
    `CHK(snap2[20:16], exp_f)
  endtask

  // Print the counts and the verdict, then end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {bv, bl, m1, m2, d1, d2, b} = '0;
    {lk.sof, lk.frame, lk.bit_stb, lk.bit_val, lk.chk_phase} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    `CHK({o_rdy, o_busy, o_crc, t_acc, t_ready}, {2'b10, 16'h0000, 16'hFFFF, 1'b1})
    @(negedge clk);
    for (int m = 0; m < 2; m++) begin
      send_pkt(32'h09000000, 1, m[0]);
      `CHK(o_crc, 16'h8F26)
      send_pkt(32'hA500FF3C, 4, m[0]);
    end
    raw(8'h09, 16'h0000, 16, 1'b1, 5'b10011);
    raw(8'h09, 16'h0400, 16, 1'b0, 5'b01101);
    raw(8'h5A, 16'h0000, 10, 1'b0, 5'b01101);
    `CHK({e_resp, e_ready}, 2'b01)
    report_and_stop();
  end
endmodule
